// *** src/cond_detect.sv ***
`timescale 1ns/1ps
module cond_detect
  import i2c_cond_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic [4:0] period,
  input wire logic fast,
  output logic start_det,
  output logic stop_det,
  output logic bus_busy
);
  function automatic logic [7:0] half_of(input logic [4:0] p);
    half_of = {4'h0, p[4:1]};
  endfunction

  logic sda_d;
  logic armed;
  logic kind_start;
  logic [7:0] high_cnt;
  logic [7:0] edge_cnt;
  logic [7:0] high_req;
  logic [7:0] setup_req;
  logic [7:0] hold_req;
  logic [7:0] busy_req;
  logic fire;

  assign high_req = fast ? FAST_HIGH_CYC : {3'h0, period} + 8'h01;
  assign setup_req = fast ? FAST_SETUP_CYC : half_of(period) + 8'h01;
  assign hold_req = fast ? FAST_HOLD_CYC : half_of(period);
  // Flag delay, half cycle rounded up
  assign busy_req = fast ? FAST_BUSY_CYC : half_of(period) + 8'h02;
  assign fire = armed && scl && (sda == sda_d) && (edge_cnt + 8'h01 >= busy_req)
    && (edge_cnt + 8'h01 >= hold_req) && (high_cnt >= high_req);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_d <= 1'b1;
      high_cnt <= 8'h00;
    end else begin
      sda_d <= sda;
      if (!scl) begin
        high_cnt <= 8'h00;
      end else if (high_cnt != 8'hFF) begin
        high_cnt <= high_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed <= 1'b0;
      kind_start <= 1'b0;
      edge_cnt <= 8'h00;
    end else if (!scl || fire) begin
      armed <= 1'b0;
    end else if (sda != sda_d) begin
      armed <= (high_cnt >= setup_req) && !armed;
      kind_start <= !sda;
      edge_cnt <= 8'h00;
    end else if (armed) begin
      edge_cnt <= edge_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_det <= 1'b0;
      stop_det <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      start_det <= fire && kind_start;
      stop_det <= fire && !kind_start;
      // Busy on START, free on STOP
      if (fire) begin
        bus_busy <= kind_start;
      end
    end
  end
endmodule

// *** src/i2c_cond_pkg.sv ***
package i2c_cond_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_SHIFT = 3'h1;
  localparam logic [2:0] ADDR_DETECT = 3'h2;
  localparam logic [2:0] ADDR_OWN = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  // Status register fields
  localparam int STAT_MASTER = 7;
  localparam int STAT_TDIR = 6;
  localparam int STAT_BUSY = 5;
  localparam int STAT_PEND = 4;
  localparam int STAT_GCALL = 2;
  localparam int STAT_AMATCH = 1;
  localparam int STAT_LRB = 0;
  // Control register fields
  localparam int CTRL_ACK = 0;
  localparam int CTRL_FAST = 1;
  // Status commands
  localparam logic [7:0] CMD_START_STANDBY = 8'hE0;
  localparam logic [7:0] CMD_STOP_STANDBY = 8'hC0;
  // Reset values and general call address
  localparam logic [4:0] DETECT_RESET = 5'h18;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h01;
  localparam logic [7:0] GENERAL_CALL = 8'h00;
  // Detection timing in core_clock cycles
  localparam logic [7:0] FAST_HIGH_CYC = 8'h04;
  localparam logic [7:0] FAST_SETUP_CYC = 8'h02;
  localparam logic [7:0] FAST_HOLD_CYC = 8'h02;
  localparam logic [7:0] FAST_BUSY_CYC = 8'h04;
  // Master bit timing
  localparam int CLK_HZ = 40000000;
  localparam int SCL_HZ = 100000;
  localparam int HALF_BIT_CYC = CLK_HZ / SCL_HZ / 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [10:0] {
    ST_IDLE = 11'b00000000001,
    ST_STANDBY = 11'b00000000010,
    ST_START = 11'b00000000100,
    ST_MLOW = 11'b00000001000,
    ST_MHIGH = 11'b00000010000,
    ST_MWAIT = 11'b00000100000,
    ST_STOP = 11'b00001000000,
    ST_SRX = 11'b00010000000,
    ST_SACK = 11'b00100000000,
    ST_SWAIT = 11'b01000000000,
    ST_STOPGEN = 11'b10000000000
  } state_type;
endpackage

// *** src/i2c_cond_xfer.sv ***
// Behaviour
// - Detection limits come from the five-bit detect_period_setting field, or from fixed values in Fast-mode.
// - START or STOP counts only when high, set-up and hold limits are met.
// - bus_busy_flag sets on START, clears on STOP.
// - Clock high needs setting plus one cycles, or four in Fast-mode.
// - Set-up needs half setting plus one cycles, or two in Fast-mode.
// - Hold needs half setting cycles, or two in Fast-mode.
// - Busy flag updates (setting-1)/2+2 cycles after edge, 3.5 in Fast-mode.
// - Writing E0h with bus free enters START standby.
// - Shift register write in START standby sends START and address.
// - Each shift register write sends one further byte.
// - C0h enters STOP standby; next shift write generates STOP.
// - General call address is acknowledged, flagged and interrupts.
// - Own address is acknowledged, flagged and interrupts.
// - With receive direction, a shift write starts slave reception.
// - Selected acknowledge level is driven on ninth clock, then interrupt.
// - Shift write after acknowledge interrupt resumes reception.
`timescale 1ns/1ps
module i2c_cond_xfer
  import i2c_cond_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  output logic irq
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl;
  logic sda;
  logic scl_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bus_busy_flag;
  logic [4:0] detect_period_setting;
  logic [6:0] own_addr_reg;
  logic ack_level_select;
  logic fast_mode;
  logic master_select;
  logic transmit_direction_flag;
  logic general_call_flag;
  logic address_match_flag;
  logic pend_reg;
  logic lrb_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt;
  logic [15:0] tick;
  logic tick_done;
  logic stop_pending;
  logic addr_phase;
  state_type state_reg;
  logic wr_shift;
  logic wr_status;
  logic scl_hold;
  logic sda_low;
  logic [7:0] status_view;

  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign wr_shift = wr && (addr == ADDR_SHIFT);
  assign wr_status = wr && (addr == ADDR_STATUS);
  assign tick_done = (tick == 16'(HALF_BIT - 1));
  assign status_view = {master_select, transmit_direction_flag, bus_busy_flag, pend_reg,
    1'b0, general_call_flag, address_match_flag, lrb_reg};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], serial_clock_pin_i};
      sda_sync <= {sda_sync[0], serial_data_pin_i};
      scl_d <= scl;
    end
  end

  cond_detect u_detect (
    .clk(clk),
    .resetn(resetn),
    .scl(scl),
    .sda(sda),
    .period(detect_period_setting),
    .fast(fast_mode),
    .start_det(start_det),
    .stop_det(stop_det),
    .bus_busy(bus_busy_flag)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      detect_period_setting <= DETECT_RESET;
      own_addr_reg <= OWN_ADDR_RESET;
      ack_level_select <= 1'b0;
      fast_mode <= 1'b0;
    end else if (wr) begin
      if (addr == ADDR_DETECT) begin
        detect_period_setting <= wdata[4:0];
      end
      if (addr == ADDR_OWN) begin
        own_addr_reg <= wdata[7:1];
      end
      if (addr == ADDR_CTRL) begin
        ack_level_select <= wdata[CTRL_ACK];
        fast_mode <= wdata[CTRL_FAST];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        ADDR_STATUS: rdata <= status_view;
        ADDR_SHIFT: rdata <= shift_reg;
        ADDR_DETECT: rdata <= {3'h0, detect_period_setting};
        ADDR_OWN: rdata <= {own_addr_reg, 1'b0};
        ADDR_CTRL: rdata <= {6'h00, fast_mode, ack_level_select};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick <= 16'h0000;
    end else if (tick_done || state_reg == ST_IDLE || state_reg == ST_MWAIT
        || state_reg == ST_STANDBY || (state_reg == ST_MHIGH && !scl)) begin
      tick <= 16'h0000;
    end else begin
      tick <= tick + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      master_select <= 1'b0;
      transmit_direction_flag <= 1'b0;
      general_call_flag <= 1'b0;
      address_match_flag <= 1'b0;
      pend_reg <= 1'b0;
      lrb_reg <= 1'b1;
      shift_reg <= 8'h00;
      bit_cnt <= 4'h0;
      stop_pending <= 1'b0;
      addr_phase <= 1'b0;
      scl_hold <= 1'b0;
      sda_low <= 1'b0;
    end else if (stop_det && !master_select) begin
      state_reg <= ST_IDLE;
      transmit_direction_flag <= 1'b0;
      general_call_flag <= 1'b0;
      address_match_flag <= 1'b0;
      scl_hold <= 1'b0;
      sda_low <= 1'b0;
    end else if (start_det && !master_select) begin
      // Slave address phase after a START seen while not master
      state_reg <= ST_SRX;
      addr_phase <= 1'b1;
      bit_cnt <= 4'h0;
      general_call_flag <= 1'b0;
      address_match_flag <= 1'b0;
      scl_hold <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      if (wr_shift) begin
        shift_reg <= wdata;
        pend_reg <= 1'b0;
      end
      unique case (state_reg)
        ST_IDLE: begin
          if (wr_status && wdata == CMD_START_STANDBY && !bus_busy_flag) begin
            state_reg <= ST_STANDBY;
            master_select <= 1'b1;
            transmit_direction_flag <= 1'b1;
          end else if (wr_status) begin
            master_select <= wdata[STAT_MASTER];
            transmit_direction_flag <= wdata[STAT_TDIR];
          end
        end
        ST_STANDBY: begin
          if (bus_busy_flag) begin
            state_reg <= ST_IDLE;
            master_select <= 1'b0;
            transmit_direction_flag <= 1'b0;
          end else if (wr_shift) begin
            state_reg <= ST_START;
            sda_low <= 1'b1;
          end
        end
        ST_START: begin
          if (tick_done) begin
            state_reg <= ST_MLOW;
            scl_hold <= 1'b1;
            bit_cnt <= 4'h0;
          end
        end
        ST_MLOW: begin
          // Data changes while the clock is low
          sda_low <= (bit_cnt == BITS_PER_BYTE) ? 1'b0 : !shift_reg[7];
          if (tick_done) begin
            state_reg <= ST_MHIGH;
            scl_hold <= 1'b0;
          end
        end
        ST_MHIGH: begin
          if (tick_done) begin
            scl_hold <= 1'b1;
            if (bit_cnt == BITS_PER_BYTE) begin
              lrb_reg <= sda;
              pend_reg <= 1'b1;
              state_reg <= ST_MWAIT;
            end else begin
              shift_reg <= {shift_reg[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
              state_reg <= ST_MLOW;
            end
          end
        end
        ST_MWAIT: begin
          sda_low <= stop_pending;
          if (wr_status && wdata == CMD_STOP_STANDBY) begin
            stop_pending <= 1'b1;
          end
          if (wr_shift) begin
            bit_cnt <= 4'h0;
            state_reg <= stop_pending ? ST_STOPGEN : ST_MLOW;
            scl_hold <= stop_pending ? 1'b0 : 1'b1;
          end
        end
        ST_STOPGEN: begin
          if (tick_done && scl) begin
            sda_low <= 1'b0;
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (!bus_busy_flag) begin
            state_reg <= ST_IDLE;
            master_select <= 1'b0;
            transmit_direction_flag <= 1'b0;
            stop_pending <= 1'b0;
          end
        end
        ST_SRX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            if (addr_phase) begin
              if (shift_reg == GENERAL_CALL) begin
                general_call_flag <= 1'b1;
                state_reg <= ST_SACK;
                sda_low <= 1'b1;
              end else if (shift_reg[7:1] == own_addr_reg) begin
                address_match_flag <= 1'b1;
                transmit_direction_flag <= shift_reg[0];
                state_reg <= ST_SACK;
                sda_low <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              sda_low <= !ack_level_select;
              state_reg <= ST_SACK;
            end
          end
        end
        ST_SACK: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
            scl_hold <= 1'b1;
            pend_reg <= 1'b1;
            state_reg <= ST_SWAIT;
          end
        end
        ST_SWAIT: begin
          if (wr_shift) begin
            scl_hold <= 1'b0;
            addr_phase <= 1'b0;
            state_reg <= transmit_direction_flag ? ST_IDLE : ST_SRX;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_clock_pin_o <= 1'b0;
      serial_data_pin_o <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      serial_data_pin_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      serial_clock_pin_o <= 1'b0;
      serial_data_pin_o <= 1'b0;
      serial_clock_pin_oe <= scl_hold;
      serial_data_pin_oe <= sda_low;
      irq <= pend_reg;
    end
  end
endmodule

// *** tb/i2c_bus_model.sv ***
`timescale 1ns/1ps
module i2c_bus_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic start();
    #400 sda_oe = 1'b1;
    #200 scl_oe = 1'b1;
  endtask
  task automatic stop();
    #25 sda_oe = 1'b1;
    #75 scl_oe = 1'b0;
    wait (scl === 1'b1);
    #200 sda_oe = 1'b0;
    #400;
  endtask
  task automatic early_start();
    scl_oe = 1'b1;
    #200 scl_oe = 1'b0;
    #50 sda_oe = 1'b1;
    #100 scl_oe = 1'b1;
    #100 sda_oe = 1'b0;
    #200 scl_oe = 1'b0;
    #400;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    #25 sda_oe = !b;
    #75 scl_oe = 1'b0;
    wait (scl === 1'b1);
    #50 s = sda;
    #50 scl_oe = 1'b1;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    #5;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask
  task automatic get(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      #40 d[i] = sda;
    end
    @(negedge scl);
    #40 sda_oe = !nack;
    @(negedge scl);
    #40 sda_oe = 1'b0;
  endtask
endmodule

// *** tb/i2c_cond_xfer_checker.sv ***
`timescale 1ns/1ps
module i2c_cond_xfer_checker
  import i2c_cond_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_i,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 8'h00) else $error("read data outside read cycle");
  unmapped_read_a: assert property (
    rd && addr > 3'h4 |=> rdata == 8'h00) else $error("unmapped read not zero");
  detect_field_a: assert property (
    wr && addr == ADDR_DETECT ##2 rd && addr == ADDR_DETECT
    |=> rdata == {3'h0, $past(wdata[4:0], 3)}) else $error("detect field readback");
  start_cause_a: assert property (
    $rose(serial_data_pin_oe) && serial_clock_pin_i && $past(serial_clock_pin_i)
    && !serial_clock_pin_oe |-> $past(wr && addr == ADDR_SHIFT, 2))
    else $error("start without shift write");
  start_hold_a: assert property (
    $rose(serial_data_pin_oe) && serial_clock_pin_i && $past(serial_clock_pin_i)
    && !serial_clock_pin_oe |-> !serial_clock_pin_oe [*8]) else $error("start hold too short");
  stop_setup_a: assert property (
    $fell(serial_data_pin_oe) && serial_clock_pin_i
    |-> !$past(serial_clock_pin_oe, 4)) else $error("stop set-up too short");
  irq_stretch_a: assert property (
    $rose(irq) |-> serial_clock_pin_oe) else $error("interrupt without clock hold");
  stretch_hold_a: assert property (
    serial_clock_pin_oe && irq && !(wr && addr == ADDR_SHIFT)
    && !$past(wr && addr == ADDR_SHIFT) |=> serial_clock_pin_oe)
    else $error("clock released without shift write");
  pins_drive_a: assert property (
    serial_clock_pin_o == 1'b0 && serial_data_pin_o == 1'b0) else $error("pin drives high");
endmodule
bind i2c_cond_xfer i2c_cond_xfer_checker #(.HALF_BIT(HALF_BIT)) chk (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_pin_i(serial_data_pin_i),
  .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe(serial_data_pin_oe), .irq(irq));

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import i2c_cond_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, p_scl_oe, p_sda_oe, ack;
  logic [7:0] got, d;
  logic [7:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;
  int seed = 96;
  int cycles = 0;
  wire scl = !(scl_oe | p_scl_oe);
  wire sda = !(sda_oe | p_sda_oe);
  always #12.5 clk = !clk;
  i2c_cond_xfer #(.HALF_BIT(10)) dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_clock_pin_i(scl), .serial_clock_pin_o(scl_o), .serial_clock_pin_oe(scl_oe),
    .serial_data_pin_i(sda), .serial_data_pin_o(sda_o), .serial_data_pin_oe(sda_oe),
    .irq(irq));
  i2c_bus_model p (.scl(scl), .sda(sda), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
  task automatic summarize();
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic wirq();
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
    check("irq", {7'h0, irq}, 8'h01);
  endtask
  task automatic wait_free();
    got = 8'hFF;
    for (int i = 0; i < 100 && got[STAT_BUSY] !== 1'b0; i++) rreg(ADDR_STATUS, got);
    check("busy", {7'h0, got[STAT_BUSY]}, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rreg(ADDR_DETECT, got);
    check("detect", got, {3'h0, DETECT_RESET});
    rreg(ADDR_OWN, got);
    check("own", got, 8'h02);
    rreg(3'h5, got);
    check("unmapped", got, 8'h00);
    wreg(ADDR_DETECT, 8'hE4);
    rreg(ADDR_DETECT, got);
    check("detect", got, 8'h04);
    p.early_start();
    rreg(ADDR_STATUS, got);
    check("status", got, 8'h01);
    fork
      p.start();
      begin
        @(posedge p_sda_oe);
        rreg(ADDR_STATUS, got);
      end
    join
    check("busy early", got, 8'h01);
    rreg(ADDR_STATUS, got);
    check("status", got, 8'h21);
    p.put({OWN_ADDR_RESET, 1'b0}, ack);
    check("addr ack", {7'h0, ack}, 8'h00);
    wirq();
    rreg(ADDR_STATUS, got);
    check("status", got, 8'h33);
    for (int n = 0; n < 2; n++) begin
      wreg(ADDR_CTRL, {7'h0, n[0]});
      d = 8'($random(seed));
      exp_q.push_back(d);
      fork
        wreg(ADDR_SHIFT, 8'h00);
        p.put(d, ack);
      join
      check("rx ack", {7'h0, ack}, {7'h0, n[0]});
      wirq();
      rreg(ADDR_SHIFT, got);
      check("rx byte", got, exp_q.pop_front());
    end
    fork
      wreg(ADDR_SHIFT, 8'h00);
      p.stop();
    join
    wait_free();
    for (int n = 0; n < 2; n++) begin
      p.start();
      p.put(n[0] ? 8'h5A : GENERAL_CALL, ack);
      check("call ack", {7'h0, ack}, {7'h0, n[0]});
      if (n == 0) begin
        wirq();
        wreg(ADDR_STATUS, CMD_START_STANDBY);
        rreg(ADDR_STATUS, got);
        check("status", got, 8'h35);
      end
      fork
        if (n == 0) wreg(ADDR_SHIFT, 8'h00);
        p.stop();
      join
      wait_free();
    end
    wreg(ADDR_STATUS, CMD_START_STANDBY);
    for (int n = 0; n < 2; n++) begin
      d = 8'($random(seed)) & (n[0] ? 8'hFF : 8'hFE);
      exp_q.push_back(d);
      fork
        wreg(ADDR_SHIFT, d);
        p.get(got, n[0]);
      join
      check("tx byte", got, exp_q.pop_front());
      wirq();
      rreg(ADDR_STATUS, got);
      check("status", got, n[0] ? 8'hF1 : 8'hF0);
    end
    wreg(ADDR_STATUS, CMD_STOP_STANDBY);
    wreg(ADDR_SHIFT, 8'h00);
    wait_free();
    summarize();
  end
endmodule
